/* File: hdl/dcd_pkg.sv */
package dcd_pkg;
  // register offsets on the plain register port
  localparam int unsigned ADDR_W    = 2;
  localparam logic [1:0]  OFF_DATA0 = 2'h0;
  localparam logic [1:0]  OFF_DATA1 = 2'h1;
  localparam logic [1:0]  OFF_CTRL  = 2'h2;
  localparam logic [1:0]  OFF_STOP  = 2'h3;
  // control register fields
  localparam int unsigned BIT_OE1   = 7;
  localparam int unsigned BIT_OE0   = 6;
  localparam int unsigned BIT_JOINT = 5;
  localparam logic [4:0]  RSV_ONES  = 5'h1f;
  // reset values
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic        STOP_RST  = 1'b1;
  // settling time of one conversion
  localparam int unsigned CLK_NS    = 100;
  localparam int unsigned CONV_NS   = 10000;
  localparam int unsigned CONV_CYC  = CONV_NS / CLK_NS;
  localparam int unsigned CNT_W     = 8;
endpackage : dcd_pkg

/* File: hdl/dcd_top.sv */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dcd_top
  import dcd_pkg::*;
(
  input  wire logic                      mclk_i,      // system clock
  input  wire logic                      rst_i,       // sync reset, high
  input  wire logic [dcd_pkg::ADDR_W-1:0] addr_i,     // register index
  input  wire logic [7:0]                wdata_i,     // write data
  input  wire logic                      wr_i,        // write strobe
  input  wire logic                      rd_i,        // read strobe
  input  wire logic                      standby_i,   // software standby
  output logic      [7:0]                rdata_o,     // read data
  output logic      [7:0]                code0_o,     // channel 0 code
  output logic      [7:0]                code1_o,     // channel 1 code
  output logic                           oe0_o,       // analog_out_pin_zero drive
  output logic                           oe1_o,       // analog_out_pin_one drive
  output logic                           conv0_on_o,  // channel 0 converter running
  output logic                           conv1_on_o,  // channel 1 converter running
  output logic                           valid0_o,    // channel 0 settled
  output logic                           valid1_o     // channel 1 settled
);
  import dcd_pkg::*;

  logic [7:0]       channel0_output_data_ff;
  logic [7:0]       channel1_output_data_ff;
  logic             channel1_output_enable_ff;
  logic             channel0_output_enable_ff;
  logic             joint_conversion_enable_ff;
  logic             stop_ff;
  logic [7:0]       ctrl_rd;
  logic             nxt_conv0;
  logic             nxt_conv1;
  logic [CNT_W-1:0] cnt0_ff;
  logic [CNT_W-1:0] cnt1_ff;
  logic             wr_ok;
  logic             standby_ff;
  logic             standby_s_ff;

  // access allowed only when module stop is clear, except the stop register
  assign wr_ok = wr_i && (!stop_ff || addr_i == OFF_STOP);
  assign ctrl_rd = {channel1_output_enable_ff, channel0_output_enable_ff,
                    joint_conversion_enable_ff, RSV_ONES};

  // module stop control
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stop_ff <= STOP_RST;
    end else if (wr_i && addr_i == OFF_STOP) begin
      stop_ff <= wdata_i[0];
    end
  end

  // data registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      channel0_output_data_ff <= DATA_RST;
      channel1_output_data_ff <= DATA_RST;
    end else if (wr_ok && addr_i == OFF_DATA0) begin
      channel0_output_data_ff <= wdata_i;
    end else if (wr_ok && addr_i == OFF_DATA1) begin
      channel1_output_data_ff <= wdata_i;
    end
  end

  // control register, low bits are not stored
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      channel1_output_enable_ff  <= 1'b0;
      channel0_output_enable_ff  <= 1'b0;
      joint_conversion_enable_ff <= 1'b0;
    end else if (wr_ok && addr_i == OFF_CTRL) begin
      channel1_output_enable_ff  <= wdata_i[BIT_OE1];
      channel0_output_enable_ff  <= wdata_i[BIT_OE0];
      joint_conversion_enable_ff <= wdata_i[BIT_JOINT];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && !stop_ff) begin
      case (addr_i)
        OFF_DATA0: rdata_o <= channel0_output_data_ff;
        OFF_DATA1: rdata_o <= channel1_output_data_ff;
        OFF_CTRL:  rdata_o <= ctrl_rd;
        default:   rdata_o <= {7'h00, stop_ff};
      endcase
    end else if (rd_i) begin
      rdata_o <= (addr_i == OFF_STOP) ? {7'h00, stop_ff} : 8'h00;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // conversion enable decode
  always_comb begin
    nxt_conv0 = channel0_output_enable_ff ||
                (joint_conversion_enable_ff && channel1_output_enable_ff);
    nxt_conv1 = channel1_output_enable_ff ||
                (joint_conversion_enable_ff && channel0_output_enable_ff);
  end

  // standby pin synchroniser
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      standby_ff   <= 1'b0;
      standby_s_ff <= 1'b0;
    end else begin
      standby_ff   <= standby_i;
      standby_s_ff <= standby_ff;
    end
  end

  // drive outputs; code follows data, pins follow output enables
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      code0_o    <= DATA_RST;
      code1_o    <= DATA_RST;
      oe0_o      <= 1'b0;
      oe1_o      <= 1'b0;
      conv0_on_o <= 1'b0;
      conv1_on_o <= 1'b0;
    end else if (!standby_s_ff) begin
      code0_o    <= channel0_output_data_ff;
      code1_o    <= channel1_output_data_ff;
      oe0_o      <= channel0_output_enable_ff;
      oe1_o      <= channel1_output_enable_ff;
      conv0_on_o <= nxt_conv0;
      conv1_on_o <= nxt_conv1;
    end
    // in standby the code, pin drive and converter outputs keep their value; rdata_o and the valid flags still update
  end

  // settle counters, restarted by a change of the data register or enable rise
  always_ff @(posedge mclk_i) begin
    if (rst_i || !conv0_on_o) begin
      cnt0_ff <= '0;
    end else if (code0_o != channel0_output_data_ff && !standby_s_ff) begin
      cnt0_ff <= '0;
    end else if (cnt0_ff != CNT_W'(CONV_CYC)) begin
      cnt0_ff <= cnt0_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !conv1_on_o) begin
      cnt1_ff <= '0;
    end else if (code1_o != channel1_output_data_ff && !standby_s_ff) begin
      cnt1_ff <= '0;
    end else if (cnt1_ff != CNT_W'(CONV_CYC)) begin
      cnt1_ff <= cnt1_ff + 1'b1;
    end
  end

  // settled flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      valid0_o <= 1'b0;
      valid1_o <= 1'b0;
    end else begin
      valid0_o <= conv0_on_o && cnt0_ff == CNT_W'(CONV_CYC);
      valid1_o <= conv1_on_o && cnt1_ff == CNT_W'(CONV_CYC);
    end
  end

  sequence s_wr_data0;
    wr_i && !stop_ff && addr_i == OFF_DATA0 && !standby_s_ff;
  endsequence

  chk_data0_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_wr_data0 ##1 (!standby_s_ff) |=> code0_o == $past(wdata_i, 2))
    else $error("channel 0 code did not follow write");
  chk_stop_blocks: assert property (@(posedge mclk_i) disable iff (rst_i)
    stop_ff && wr_i && addr_i == OFF_DATA1 |=> $stable(channel1_output_data_ff))
    else $error("write accepted under module stop");
  chk_stop_ctrl: assert property (@(posedge mclk_i) disable iff (rst_i)
    stop_ff && wr_i && addr_i == OFF_CTRL |=> $stable(ctrl_rd))
    else $error("control written under module stop");
  chk_reserved_ones: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && !stop_ff && addr_i == OFF_CTRL |=> rdata_o[4:0] == RSV_ONES)
    else $error("reserved control bits not one");
  chk_joint_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
    joint_conversion_enable_ff && channel0_output_enable_ff && !standby_s_ff
      |=> conv1_on_o)
    else $error("joint mode did not enable channel 1");
  chk_oe1_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    !channel1_output_enable_ff && !standby_s_ff |=> !oe1_o)
    else $error("channel 1 driven while disabled");
  chk_oe0_on: assert property (@(posedge mclk_i) disable iff (rst_i)
    channel0_output_enable_ff && !standby_s_ff |=> oe0_o && conv0_on_o)
    else $error("channel 0 not enabled");
  chk_indiv_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
    !joint_conversion_enable_ff && !channel1_output_enable_ff && !standby_s_ff
      |=> !conv1_on_o)
    else $error("channel 1 converts in individual mode");
  chk_standby_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    standby_s_ff |=> $stable(code0_o) && $stable(code1_o) && $stable(oe0_o)
      && $stable(oe1_o) && $stable(conv0_on_o) && $stable(conv1_on_o))
    else $error("output changed in standby");
  chk_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv0_on_o && !standby_s_ff && code0_o != channel0_output_data_ff
      |=> cnt0_ff == '0)
    else $error("conversion not restarted on data change");
  chk_data_reset: assert property (@(posedge mclk_i)
    rst_i |=> channel0_output_data_ff == DATA_RST && channel1_output_data_ff == DATA_RST)
    else $error("data registers not cleared");
  chk_ctrl_reset: assert property (@(posedge mclk_i)
    rst_i |=> ctrl_rd == 8'h1f)
    else $error("control reset value wrong");
endmodule : dcd_top

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dcd_pkg::*;
  logic              mclk_i, rst_i, wr_i, rd_i, standby_i;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0]        wdata_i, rdata_o, code0_o, code1_o;
  logic              oe0_o, oe1_o, conv0_on_o, conv1_on_o, valid0_o, valid1_o;
  int                n_mismatch = 0;
  int                total_checks = 0;
  int                cnt;
  logic [7:0]        c;
  dcd_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .standby_i(standby_i), .rdata_o(rdata_o),
    .code0_o(code0_o), .code1_o(code1_o), .oe0_o(oe0_o), .oe1_o(oe1_o),
    .conv0_on_o(conv0_on_o), .conv1_on_o(conv1_on_o), .valid0_o(valid0_o),
    .valid1_o(valid1_o));
  // free-running 10 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // one-cycle register write, strobe left for the next call to change
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1; rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  // one-cycle read, data sampled in the following cycle
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    addr_i <= a; rd_i <= 1'b1; wr_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk("read data", rdata_o, exp);
  endtask : rd
  // strobes low for n cycles
  task automatic idle(input int n);
    wr_i <= 1'b0; rd_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : idle
  // enables as {oe1, oe0, conv1, conv0}
  task automatic outs(input logic [3:0] e);
    chk("enables", {4'h0, oe1_o, oe0_o, conv1_on_o, conv0_on_o}, {4'h0, e});
  endtask : outs
  // bounded wait for channel 0 to settle
  task automatic wait_valid0;
    for (cnt = 0; cnt < 300 && valid0_o !== 1'b1; cnt++) idle(1);
    if (cnt >= 300) begin
      n_mismatch++;
      $display("ERROR settle timeout expected 1 seen 0");
      summarize();
    end
  endtask : wait_valid0
  initial begin
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; standby_i = 1'b0;
    addr_i = '0; wdata_i = 8'h00;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    idle(1);
    // module stop blocks access after reset
    outs(4'h0);
    rd(OFF_CTRL, 8'h00);
    wr(OFF_DATA0, 8'h77);
    wr(OFF_DATA1, 8'h66);
    wr(OFF_CTRL, 8'he0);
    wr(OFF_STOP, 8'h00);
    rd(OFF_DATA0, 8'h00);
    rd(OFF_DATA1, 8'h00);
    rd(OFF_CTRL, 8'h1f);
    $display("test reset done");
    // data readback and reserved bits
    wr(OFF_DATA0, 8'ha5);
    wr(OFF_DATA1, 8'h3c);
    wr(OFF_CTRL, 8'h20);
    rd(OFF_DATA0, 8'ha5);
    rd(OFF_DATA1, 8'h3c);
    rd(OFF_CTRL, 8'h3f);
    $display("test registers done");
    // every enable combination
    for (int i = 0; i < 8; i++) begin
      c = {i[2:0], 5'h00};
      wr(OFF_CTRL, c);
      idle(2);
      outs({c[7], c[6], c[7] | (c[5] & c[6]), c[6] | (c[5] & c[7])});
      if (conv0_on_o === 1'b1) chk("code0", code0_o, 8'ha5);
      if (conv1_on_o === 1'b1) chk("code1", code1_o, 8'h3c);
    end
    $display("test decode done");
    // data write restarts conversion
    wr(OFF_CTRL, 8'h40);
    idle(2);
    wait_valid0();
    wr(OFF_DATA0, 8'h5a);
    idle(2);
    chk("valid0 after write", {7'h00, valid0_o}, 8'h00);
    chk("code0 after write", code0_o, 8'h5a);
    wait_valid0();
    chk("settle long enough", {7'h00, cnt >= CONV_CYC - 4}, 8'h01);
    chk("code0 held", code0_o, 8'h5a);
    $display("test restart done");
    // standby keeps the enabled output
    standby_i <= 1'b1;
    idle(4);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_DATA0, 8'h11);
    idle(3);
    outs(4'h5);
    chk("code0 in standby", code0_o, 8'h5a);
    rd(OFF_CTRL, 8'h1f);
    standby_i <= 1'b0;
    idle(5);
    outs(4'h0);
    $display("test standby done");
    // reset in mid-run clears the data and sets module stop again
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rd(OFF_STOP, 8'h01);
    rd(OFF_DATA0, 8'h00);
    wr(OFF_STOP, 8'h00);
    rd(OFF_DATA0, 8'h00);
    rd(OFF_DATA1, 8'h00);
    rd(OFF_CTRL, 8'h1f);
    outs(4'h0);
    $display("test reset again done");
    // channel 1 with joint control, settles like channel 0
    wr(OFF_DATA1, 8'hc3);
    wr(OFF_CTRL, 8'ha0);
    idle(2);
    outs(4'hb);
    chk("valid1 at start", {7'h00, valid1_o}, 8'h00);
    chk("code1 joint", code1_o, 8'hc3);
    for (cnt = 0; cnt < 300 && valid1_o !== 1'b1; cnt++) idle(1);
    chk("settle1 long enough", {7'h00, cnt >= CONV_CYC - 4 && cnt < 300}, 8'h01);
    chk("code1 held", code1_o, 8'hc3);
    $display("test channel 1 done");
    summarize();
  end
endmodule : tb_top
